// ===== rtl/tws_pkg.sv
// Purpose: Shared constants, types and helpers for the two-word burst DDR SRAM port.
// Assumes: Input clock pair is oversampled by the system clock (8 samples per period).
// Notes: Timing is counted in half-cycle ticks, one tick per rising edge of either input clock.
package tws_pkg;

  // Word width of the widest organisation
  localparam int WORD_W_DEF = 36;
  // Words per address location
  localparam int BURST_LEN = 2;
  // Lane widths: nibble lanes for 8-bit words, byte lanes otherwise
  localparam int NIBBLE_W = 4;
  localparam int BYTE_W = 9;
  // Read latency of 2.5 input cycles, in half-cycle ticks
  localparam int RD_LAT_HALF = 5;
  // Tick at which read words are fetched from the core, before the next address edge
  localparam int RD_FETCH_TICK = 3;
  // Ticks after the address edge that carry the two write beats
  localparam int WR_BEAT0_TICK = 2;
  localparam int WR_BEAT1_TICK = 3;
  // Input synchroniser depth
  localparam int SYNC_STAGES = 2;

  // Location address width per word width
  function automatic int addr_w(input int word_w);
    if (word_w == 8 || word_w == 9) begin
      return 21;
    end else if (word_w == 18) begin
      return 20;
    end
    return 19;
  endfunction

  // Number of write select lanes per word width
  function automatic int lanes(input int word_w);
    if (word_w == 8) begin
      return word_w / NIBBLE_W;
    end
    return word_w / BYTE_W;
  endfunction

  // Control pins sampled at an address edge
  typedef struct packed {
    logic load_n;
    logic read_sel;
  } tws_ctl_s;

  // Rising edges of the input clock pair
  typedef struct packed {
    logic k_rise;
    logic kn_rise;
  } tws_edge_s;

  // Self-timed core write sequencer
  typedef enum logic [1:0] {
    CORE_IDLE,
    CORE_WORD0,
    CORE_WORD1
  } tws_core_e;

endpackage

// ===== rtl/tws_core.sv
// Purpose: Storage core with a self-timed two-word write sequencer.
// Assumes: A write command arrives at most once per address slot.
// Notes: Storage is plain flip-flops; read data is combinational from the array.
`timescale 1ns/1ps
module tws_core #(
  parameter int WORD_W = tws_pkg::WORD_W_DEF,
  parameter int ADDR_W = tws_pkg::addr_w(WORD_W),
  parameter int LANES = tws_pkg::lanes(WORD_W)
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Write command
  input wire logic wr_go_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [2*WORD_W-1:0] wr_data_in,
  input wire logic [2*LANES-1:0] wr_lane_en_in,
  // Read port
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [2*WORD_W-1:0] rd_data_out
);

  localparam int LANE_W = WORD_W / LANES;

  tws_pkg::tws_core_e state;
  tws_pkg::tws_core_e next_state;
  logic [ADDR_W-1:0] cmd_addr;
  logic [2*WORD_W-1:0] cmd_data;
  logic [2*LANES-1:0] cmd_lane_en;
  logic [WORD_W-1:0] mem [0:(2**ADDR_W)*tws_pkg::BURST_LEN-1];

  // Lanes left disabled keep their old bits
  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old_w,
                                              input logic [WORD_W-1:0] new_w,
                                              input logic [LANES-1:0] en);
    logic [WORD_W-1:0] res;
    res = old_w;
    for (int b = 0; b < WORD_W; b++) begin
      if (en[b / LANE_W]) begin
        res[b] = new_w[b];
      end
    end
    return res;
  endfunction

  wire logic word_sel = (state == tws_pkg::CORE_WORD1);
  wire logic do_write = (state != tws_pkg::CORE_IDLE);
  wire logic [ADDR_W:0] wr_idx = {cmd_addr, word_sel};
  wire logic [WORD_W-1:0] wr_word = word_sel ? cmd_data[2*WORD_W-1:WORD_W]
                                             : cmd_data[WORD_W-1:0];
  wire logic [LANES-1:0] wr_en = word_sel ? cmd_lane_en[2*LANES-1:LANES]
                                          : cmd_lane_en[LANES-1:0];

  assign rd_data_out = {mem[{rd_addr_in, 1'b1}], mem[{rd_addr_in, 1'b0}]};

  // Sequencer runs on its own once the command is latched
  always_comb begin
    next_state = state;
    unique case (state)
      tws_pkg::CORE_IDLE: next_state = wr_go_in ? tws_pkg::CORE_WORD0 : tws_pkg::CORE_IDLE;
      tws_pkg::CORE_WORD0: next_state = tws_pkg::CORE_WORD1;
      tws_pkg::CORE_WORD1: next_state = wr_go_in ? tws_pkg::CORE_WORD0 : tws_pkg::CORE_IDLE;
      default: next_state = tws_pkg::CORE_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= tws_pkg::CORE_IDLE;
      cmd_addr <= '0;
      cmd_data <= '0;
      cmd_lane_en <= '0;
    end else begin
      state <= next_state;
      if (wr_go_in) begin
        cmd_addr <= wr_addr_in;
        cmd_data <= wr_data_in;
        cmd_lane_en <= wr_lane_en_in;
      end
    end
  end

  // Array has no reset: contents are undefined until written
  always_ff @(posedge clk_in) begin
    if (do_write) begin
      mem[wr_idx] <= merge(mem[wr_idx], wr_word, wr_en);
    end
  end

endmodule

// ===== rtl/tws_port.sv
// Purpose: Device-side pin logic of a two-word burst DDR SRAM with 2.5-cycle read latency.
// Assumes: Input clock pair runs far below the system clock and is sampled by it.
// Notes: One tick is a rising edge of either input clock; latencies count ticks.
//
// Function
// - Addresses taken on alternate true-clock rising edges
// - Write beats on true and complement clock rises
// - Read beats launched on either clock rise
// - Falling clock edges are ignored
// - Each address holds two words, fixed order
// - First read beat 2.5 cycles after address
// - Word width 8, 9, 18 or 36
// - Valid flag marks driven read beats
// - Echo strobes track the read data
// - Shared data pins, controller releases during reads
// - Inputs and outputs pass through edge registers
// - Core write completes self-timed after capture
`timescale 1ns/1ps
module tws_port #(
  parameter int WORD_W = tws_pkg::WORD_W_DEF,
  parameter int ADDR_W = tws_pkg::addr_w(WORD_W),
  parameter int LANES = tws_pkg::lanes(WORD_W)
) (
  // System clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Input clock pair
  input wire logic kclk_in,
  input wire logic kclk_n_in,
  // Address and control
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic load_strobe_n_in,
  input wire logic read_sel_in,
  input wire logic [LANES-1:0] byte_write_select_n_in,
  // Shared data pins
  input wire logic [WORD_W-1:0] dq_in,
  output logic [WORD_W-1:0] dq_out,
  output logic dq_oe_out,
  // Echo strobes and valid flag
  output logic echo_strobe_out,
  output logic echo_strobe_n_out,
  output logic read_valid_flag_out
);

  localparam int PIN_W = 4 + ADDR_W + LANES + WORD_W;
  localparam int RD_SR_W = tws_pkg::RD_LAT_HALF + 1;
  localparam int WR_SR_W = tws_pkg::WR_BEAT1_TICK;
  // Idle pin levels: true clock low, complement high, load high
  localparam logic [PIN_W-1:0] PIN_RST = {1'b0, 1'b1, 1'b1, {(PIN_W-3){1'b0}}};

  // Two-stage synchroniser for every pin
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  wire logic [PIN_W-1:0] pin_raw = {kclk_in, kclk_n_in, load_strobe_n_in, read_sel_in,
                                    addr_in, byte_write_select_n_in, dq_in};

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // Idle levels so no false clock rise follows reset
      pin_s1 <= PIN_RST;
      pin_s2 <= PIN_RST;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // Unpacked synchronised pins
  wire logic k_s = pin_s2[PIN_W-1];
  wire logic kn_s = pin_s2[PIN_W-2];
  tws_pkg::tws_ctl_s ctl;
  assign ctl = pin_s2[PIN_W-3 -: 2];
  wire logic [ADDR_W-1:0] addr_s = pin_s2[LANES+WORD_W +: ADDR_W];
  wire logic [LANES-1:0] sel_n_s = pin_s2[WORD_W +: LANES];
  wire logic [WORD_W-1:0] dq_s = pin_s2[WORD_W-1:0];

  // Rising-edge detection only
  logic k_prev;
  logic kn_prev;
  tws_pkg::tws_edge_s edge_det;
  assign edge_det = {k_s & ~k_prev, kn_s & ~kn_prev};
  wire logic tick = edge_det.k_rise | edge_det.kn_rise;

  // Reset to high so a clock already high at release is not a rise
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      k_prev <= 1'b1;
      kn_prev <= 1'b1;
    end else begin
      k_prev <= k_s;
      kn_prev <= kn_s;
    end
  end

  // Address slot phase: every other true-clock rise is an address edge
  logic phase;
  wire logic addr_edge = edge_det.k_rise & ~phase;
  wire logic start_rd = addr_edge & ~ctl.load_n & ctl.read_sel;
  wire logic start_wr = addr_edge & ~ctl.load_n & ~ctl.read_sel;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase <= 1'b0;
    end else if (edge_det.k_rise) begin
      phase <= ~phase;
    end
  end

  // Tick pipelines: bit n set means n+1 ticks since the address edge
  logic [RD_SR_W-1:0] rd_sr;
  logic [WR_SR_W-1:0] wr_sr;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_sr <= '0;
      wr_sr <= '0;
    end else if (tick) begin
      rd_sr <= {rd_sr[RD_SR_W-2:0], start_rd};
      wr_sr <= {wr_sr[WR_SR_W-2:0], start_wr};
    end
  end

  wire logic rd_fetch = tick & rd_sr[tws_pkg::RD_FETCH_TICK-1];
  wire logic rd_beat0 = tick & rd_sr[tws_pkg::RD_LAT_HALF-1];
  wire logic rd_beat1 = tick & rd_sr[tws_pkg::RD_LAT_HALF];
  wire logic wr_beat0 = tick & wr_sr[tws_pkg::WR_BEAT0_TICK-1];
  wire logic wr_beat1 = tick & wr_sr[tws_pkg::WR_BEAT1_TICK-1];

  // Read path: address held, words fetched before the next address edge
  logic [ADDR_W-1:0] rd_addr;
  logic [2*WORD_W-1:0] rd_buf;
  logic [2*WORD_W-1:0] core_rd_data;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_addr <= '0;
      rd_buf <= '0;
    end else begin
      if (start_rd) begin
        rd_addr <= addr_s;
      end
      // Fetch late so a write from the previous slot has landed
      if (rd_fetch) begin
        rd_buf <= core_rd_data;
      end
    end
  end

  // Read drive: word 0 on the complement rise, word 1 on the next true rise
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dq_out <= '0;
      dq_oe_out <= 1'b0;
      read_valid_flag_out <= 1'b0;
    end else if (rd_beat0) begin
      dq_out <= rd_buf[WORD_W-1:0];
      dq_oe_out <= 1'b1;
      read_valid_flag_out <= 1'b1;
    end else if (rd_beat1) begin
      dq_out <= rd_buf[2*WORD_W-1:WORD_W];
      dq_oe_out <= 1'b1;
      read_valid_flag_out <= 1'b1;
    end else if (tick) begin
      // Pins released on the tick after the last beat
      dq_oe_out <= 1'b0;
      read_valid_flag_out <= 1'b0;
    end
  end

  // Echo strobes take the same register stage as the data
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      echo_strobe_out <= 1'b0;
      echo_strobe_n_out <= 1'b0;
    end else begin
      echo_strobe_out <= k_s;
      echo_strobe_n_out <= kn_s;
    end
  end

  // Write path: two beats captured, then handed to the core
  logic [ADDR_W-1:0] wr_addr;
  logic [2*WORD_W-1:0] wr_data;
  logic [2*LANES-1:0] wr_lane_en;
  logic wr_go;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_addr <= '0;
      wr_data <= '0;
      wr_lane_en <= '0;
      wr_go <= 1'b0;
    end else begin
      wr_go <= wr_beat1;
      if (start_wr) begin
        wr_addr <= addr_s;
      end
      if (wr_beat0) begin
        wr_data[WORD_W-1:0] <= dq_s;
        wr_lane_en[LANES-1:0] <= ~sel_n_s;
      end
      if (wr_beat1) begin
        wr_data[2*WORD_W-1:WORD_W] <= dq_s;
        wr_lane_en[2*LANES-1:LANES] <= ~sel_n_s;
      end
    end
  end

  // Storage core sized by word width
  tws_core #(
    .WORD_W(WORD_W),
    .ADDR_W(ADDR_W),
    .LANES(LANES)
  ) u_core (
    .clk_in(clk_sys_in),
    .rstn_in(rstn_in),
    .wr_go_in(wr_go),
    .wr_addr_in(wr_addr),
    .wr_data_in(wr_data),
    .wr_lane_en_in(wr_lane_en),
    .rd_addr_in(rd_addr),
    .rd_data_out(core_rd_data)
  );

endmodule

// ===== tb/tws_port_properties.sv
// Purpose: Port checks of read timing, echo strobes and valid flag.
// Assumes: Input clock period of 8 system cycles.
// Notes: Cycle figures hold only at that ratio.
`timescale 1ns/1ps
module tws_port_properties #(
  parameter int WORD_W = tws_pkg::WORD_W_DEF,
  parameter int ADDR_W = 19,
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Controller side
  input wire logic kclk_in,
  input wire logic kclk_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic load_strobe_n_in,
  input wire logic read_sel_in,
  input wire logic [LANES-1:0] byte_write_select_n_in,
  input wire logic [WORD_W-1:0] dq_in,
  // Device side
  input wire logic [WORD_W-1:0] dq_out,
  input wire logic dq_oe_out,
  input wire logic echo_strobe_out,
  input wire logic echo_strobe_n_out,
  input wire logic read_valid_flag_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  a_valid_is_oe: assert property (read_valid_flag_out == dq_oe_out)
    else $error("valid flag differs from drive enable");
  a_valid_two_beats: assert property ($rose(read_valid_flag_out) |->
    read_valid_flag_out [*8] ##1 !read_valid_flag_out)
    else $error("valid flag not two beats long");
  a_read_drives: assert property ($rose(dq_oe_out) |->
    $past(read_sel_in, 23) && !$past(load_strobe_n_in, 23))
    else $error("drive without a read at the right address edge");
  a_word0_on_kn: assert property ($rose(dq_oe_out) |->
    echo_strobe_n_out && !echo_strobe_out)
    else $error("first beat not with complement echo");
  a_word0_hold: assert property ($rose(dq_oe_out) |=> $stable(dq_out) [*3])
    else $error("first word did not stand one beat");
  a_word1_on_k: assert property ($rose(dq_oe_out) |-> ##[3:5] $rose(echo_strobe_out))
    else $error("second beat not with true echo");
  a_echo_true: assert property ($rose(kclk_in) |-> ##[1:4] $rose(echo_strobe_out))
    else $error("true echo does not follow input clock");
  a_echo_comp: assert property ($rose(kclk_n_in) |-> ##[1:4] $rose(echo_strobe_n_out))
    else $error("complement echo does not follow input clock");
  a_release_on_kn: assert property ($fell(dq_oe_out) |-> echo_strobe_n_out)
    else $error("pins released off the complement edge");
endmodule

// ===== tb/tws_ctl_model.sv
// Purpose: Memory controller model: clock pair, address slots, write beats.
// Assumes: Input clock of 8 system cycles, started after reset.
// Notes: Released data pins show the inverse of the last value.
`timescale 1ns/1ps
module tws_ctl_model #(
  parameter int W = 36,
  parameter int A = 4,
  parameter int L = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Pins toward the device
  output logic kclk_out,
  output logic kclk_n_out,
  output logic [A-1:0] addr_out,
  output logic load_n_out,
  output logic rsel_out,
  output logic [L-1:0] sel_n_out,
  output logic [W-1:0] dq_out
);
  logic [1:0] wait_cnt;
  logic [3:0] cnt;
  wire run = (wait_cnt == 2'h3);
  // Address edge at cnt 0, one address per two periods
  assign kclk_out = run && !cnt[2];
  assign kclk_n_out = !kclk_out;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_cnt <= 2'h0;
      cnt <= 4'h0;
    end else if (!run) begin
      wait_cnt <= wait_cnt + 2'h1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  initial begin
    addr_out = '0;
    load_n_out = 1'b1;
    rsel_out = 1'b0;
    sel_n_out = '1;
    dq_out = '0;
  end
  task automatic tick_to(input logic [3:0] c);
    do @(posedge clk_in); while (cnt != c);
  endtask
  task automatic slot(input logic ld_n, rs, input logic [A-1:0] a,
                      input logic [W-1:0] w0, w1, input logic [L-1:0] m0, m1);
    tick_to(4'hd);
    addr_out <= a;
    load_n_out <= ld_n;
    rsel_out <= rs;
    tick_to(4'h5);
    if (ld_n || rs) begin
      dq_out <= ~dq_out;
    end else begin
      dq_out <= w0;
      sel_n_out <= m0;
      tick_to(4'h9);
      dq_out <= w1;
      sel_n_out <= m1;
    end
  endtask
endmodule

// ===== tb/tws_port_tb.sv
// Purpose: Self-checking bench for the burst SRAM port.
// Assumes: Small address space for a short run.
// Notes: Reads are compared by a monitor against queued notes.
`timescale 1ns/1ps
module tws_port_tb;
  localparam int W = 36;
  localparam int A = 4;
  localparam int L = tws_pkg::lanes(W);
  localparam int LW = W / L;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic kclk, kclk_n, load_n, rsel, dq_oe, echo, echo_n, valid;
  logic [A-1:0] addr;
  logic [L-1:0] sel_n;
  logic [W-1:0] ctl_dq, dq_out, dq_in;
  logic [W-1:0] mem [2**(A+1)];
  logic [2*W-1:0] exp_q [$];
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  // Device wins the shared pins only while it drives
  assign dq_in = dq_oe ? dq_out : ctl_dq;
  tws_ctl_model #(.W(W), .A(A), .L(L)) i_ctl (.clk_in(clk_sys_in), .rstn_in(rstn_in),
    .kclk_out(kclk), .kclk_n_out(kclk_n), .addr_out(addr), .load_n_out(load_n),
    .rsel_out(rsel), .sel_n_out(sel_n), .dq_out(ctl_dq));
  tws_port #(.WORD_W(W), .ADDR_W(A)) i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .kclk_in(kclk), .kclk_n_in(kclk_n), .addr_in(addr), .load_strobe_n_in(load_n),
    .read_sel_in(rsel), .byte_write_select_n_in(sel_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_out(dq_oe), .echo_strobe_out(echo), .echo_strobe_n_out(echo_n),
    .read_valid_flag_out(valid));
  task automatic check(input string what, input logic [W-1:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [A-1:0] a, input logic [L-1:0] m0, m1);
    logic [W-1:0] w0, w1;
    w0 = W'({$urandom, $urandom});
    w1 = W'({$urandom, $urandom});
    for (int i = 0; i < L; i++) begin
      if (!m0[i]) mem[{a, 1'b0}][i*LW +: LW] = w0[i*LW +: LW];
      if (!m1[i]) mem[{a, 1'b1}][i*LW +: LW] = w1[i*LW +: LW];
    end
    i_ctl.slot(1'b0, 1'b0, a, w0, w1, m0, m1);
  endtask
  task automatic rd(input logic [A-1:0] a);
    exp_q.push_back({mem[{a, 1'b1}], mem[{a, 1'b0}]});
    i_ctl.slot(1'b0, 1'b1, a, '0, '0, '1, '1);
  endtask
  // Load high with read select high must stay silent
  task automatic nop();
    i_ctl.slot(1'b1, 1'b1, '0, '0, '0, '1, '1);
  endtask
  initial begin
    logic [2*W-1:0] e;
    forever begin
      @(posedge clk_sys_in iff valid === 1'b1);
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      @(posedge clk_sys_in);
      check("word0", dq_out, e[W-1:0]);
      repeat (4) @(posedge clk_sys_in);
      check("word1", dq_out, e[2*W-1:W]);
      @(posedge clk_sys_in iff valid === 1'b0);
    end
  end
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    logic [A-1:0] a;
    void'($urandom(32'hcdc2));
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(A'(i), '0, '0);
    end
    nop();
    for (int i = 0; i < 8; i++) begin
      rd(A'(i));
    end
    nop();
    // Masked write read straight back, gap before the next write
    for (int i = 0; i < 6; i++) begin
      a = A'($urandom_range(7));
      wr(a, L'($urandom), L'($urandom));
      rd(a);
      nop();
    end
    repeat (64) @(posedge clk_sys_in);
    check("pending", W'(exp_q.size()), '0);
    wrap_up();
  end
endmodule
bind tws_port tws_port_properties #(.WORD_W(WORD_W), .ADDR_W(ADDR_W), .LANES(LANES)) i_props (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .kclk_in(kclk_in), .kclk_n_in(kclk_n_in),
  .addr_in(addr_in), .load_strobe_n_in(load_strobe_n_in), .read_sel_in(read_sel_in),
  .byte_write_select_n_in(byte_write_select_n_in), .dq_in(dq_in), .dq_out(dq_out),
  .dq_oe_out(dq_oe_out), .echo_strobe_out(echo_strobe_out),
  .echo_strobe_n_out(echo_strobe_n_out), .read_valid_flag_out(read_valid_flag_out));
